// ---- rtl/rbsc_consts.svh ----
// Operation
// - four sources pin watchdog poweron brownout reset chip
// - reset starts oscillator and flash controller init
// - release fetches address zero, registers at defaults
// - four interrupt thresholds raise brownout interrupt
// - brownout interrupt level readable in status register
// - four reset thresholds force chip reset
// - protection level set by flash pattern only
// - application programming unaffected by protection
// - boot pin programming entry separately disableable
// - level one blocks debug, protects sector zero
// - level two blocks debug, erase-all then update
// - level three blocks debug and system programming
// - level three ignores boot select pin
// - boot pin user code sampling separately disableable
// - reset pin low scan, high serial debug
// - serial debug disabled while in reset
// - boundary scan unaffected by protection
// - four breakpoints and two watchpoints maximum
`ifndef RBSC_CONSTS_SVH
`define RBSC_CONSTS_SVH
`define RBSC_ADDR_CTRL 12'h000
`define RBSC_ADDR_STAT 12'h004
`define RBSC_ADDR_PROT 12'h008
`define RBSC_ADDR_CAPS 12'h00C
`define RBSC_CTRL_RST 6'h00
`define RBSC_PAT_L1 32'h1234_5678
`define RBSC_PAT_L2 32'h8765_4321
`define RBSC_PAT_L3 32'h4321_8765
`define RBSC_PAT_NOBOOT 32'h4E69_7370
`define RBSC_RESET_VECTOR 32'h0000_0000
`define RBSC_INIT_CYCLES 8'h10
`define RBSC_BREAKPOINTS 3'h4
`define RBSC_WATCHPOINTS 3'h2
`define RBSC_SCAN_WAIT_US 16'h00FA
`endif

// ---- rtl/rbsc_pkg.sv ----
package rbsc_pkg;
	typedef enum logic [1:0] {PROT_NONE, PROT_ONE, PROT_TWO, PROT_THREE} prot_level_t;
	typedef enum logic [1:0] {SEQ_RESET, SEQ_INIT, SEQ_RUN} seq_state_t;
	typedef struct packed {
		logic [1:0] int_level;
		logic [1:0] rst_level;
		logic rst_enable;
		logic int_enable;
	} bod_ctrl_t;
	typedef struct packed {
		logic swd_enable;
		logic scan_enable;
		logic isp_allowed;
		logic isp_sector0_allowed;
		logic isp_erase_only;
		logic boot_pin_enable;
		logic iap_allowed;
	} access_t;
	typedef struct packed {
		logic [1:0] sync;
		logic [1:0] in_sync;
		logic [2:0] bod_int_sync;
		seq_state_t seq;
		logic [7:0] cnt;
		logic chip_rst_n;
		logic irc_en;
		logic flash_init;
		logic fetch_valid;
		bod_ctrl_t bod;
		logic bod_irq;
		logic bod_rst;
		prot_level_t level;
		logic no_boot_pin;
		access_t acc;
		logic jtag_sel;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} state_t;
endpackage : rbsc_pkg

// ---- rtl/reset_bod_security_control.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rbsc_consts.svh"
module reset_bod_security_control
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// reset sources
	input wire logic reset_pin_n_i,
	input wire logic watchdog_rst_i,
	input wire logic por_i,
	// brownout comparators, one per threshold
	input wire logic [3:0] bod_below_i,
	// protection pattern read from flash
	input wire logic [31:0] crp_word_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	// system outputs
	output logic chip_rst_n_o,
	output logic irc_en_o,
	output logic flash_init_o,
	output logic fetch_valid_o,
	output logic bod_irq_o,
	output logic swd_enable_o,
	output logic scan_enable_o,
	output logic isp_allowed_o,
	output logic isp_sector0_o,
	output logic isp_erase_only_o,
	output logic boot_pin_enable_o,
	output logic iap_allowed_o,
	output logic jtag_sel_o
);
	localparam int INIT_W = 8;
	if (INIT_W < 4)
	begin : g_init_w_check
		$error("init counter too narrow");
	end

	logic rst_s1;
	logic rst_n;
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	rbsc_pkg::state_t st;
	rbsc_pkg::state_t next_st;
	logic any_src;
	logic bod_int_lvl;
	logic bod_rst_lvl;
	logic wr;
	logic rd;

	assign bod_int_lvl = bod_below_i[st.bod.int_level];
	assign bod_rst_lvl = bod_below_i[st.bod.rst_level] & st.bod.rst_enable;
	// level inputs are synchronous, so the sources combine directly
	assign any_src = !reset_pin_n_i | watchdog_rst_i | por_i | st.bod_rst;
	assign wr = psel_i & penable_i & pwrite_i & !st.pready;
	assign rd = psel_i & penable_i & !pwrite_i & !st.pready;

	always_comb
	begin
		next_st = st;
		next_st.bod_rst = bod_rst_lvl;
		next_st.bod_irq = bod_int_lvl & st.bod.int_enable;
		next_st.bod_int_sync = {st.bod_int_sync[1:0], bod_int_lvl};
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		case (st.seq)
			rbsc_pkg::SEQ_RESET:
			begin
				next_st.chip_rst_n = 1'b0;
				next_st.fetch_valid = 1'b0;
				next_st.irc_en = 1'b1;
				next_st.flash_init = 1'b1;
				next_st.cnt = `RBSC_INIT_CYCLES;
				// reset pin level decides debug mode while held
				next_st.jtag_sel = !reset_pin_n_i;
				if (!any_src)
					next_st.seq = rbsc_pkg::SEQ_INIT;
			end
			rbsc_pkg::SEQ_INIT:
			begin
				next_st.cnt = st.cnt - 8'h01;
				if (any_src)
					next_st.seq = rbsc_pkg::SEQ_RESET;
				else if (st.cnt == 8'h00)
				begin
					// pattern is latched only once flash init finishes
					next_st.flash_init = 1'b0;
					next_st.seq = rbsc_pkg::SEQ_RUN;
					next_st.chip_rst_n = 1'b1;
					next_st.fetch_valid = 1'b1;
					next_st.no_boot_pin = crp_word_i == `RBSC_PAT_NOBOOT;
					case (crp_word_i)
						`RBSC_PAT_L1: next_st.level = rbsc_pkg::PROT_ONE;
						`RBSC_PAT_L2: next_st.level = rbsc_pkg::PROT_TWO;
						`RBSC_PAT_L3: next_st.level = rbsc_pkg::PROT_THREE;
						default: next_st.level = rbsc_pkg::PROT_NONE;
					endcase
				end
			end
			rbsc_pkg::SEQ_RUN:
			begin
				if (any_src)
				begin
					next_st.seq = rbsc_pkg::SEQ_RESET;
					next_st.chip_rst_n = 1'b0;
					// fetch must never outlive the chip reset by a cycle
					next_st.fetch_valid = 1'b0;
					next_st.flash_init = 1'b1;
					next_st.bod = '0;
				end
			end
			default: next_st.seq = rbsc_pkg::SEQ_RESET;
		endcase
		next_st.acc.iap_allowed = 1'b1;
		next_st.acc.scan_enable = 1'b1;
		next_st.acc.swd_enable = next_st.chip_rst_n & !next_st.jtag_sel
			& (next_st.level == rbsc_pkg::PROT_NONE);
		next_st.acc.isp_allowed = next_st.level != rbsc_pkg::PROT_THREE;
		next_st.acc.isp_sector0_allowed = next_st.level == rbsc_pkg::PROT_NONE;
		next_st.acc.isp_erase_only = next_st.level == rbsc_pkg::PROT_TWO;
		next_st.acc.boot_pin_enable = !next_st.no_boot_pin
			& (next_st.level != rbsc_pkg::PROT_THREE);
		if (psel_i & penable_i & !st.pready)
		begin
			next_st.pready = 1'b1;
			next_st.prdata = '0;
			case (paddr_i)
				`RBSC_ADDR_CTRL:
				begin
					if (wr)
						next_st.bod = pwdata_i[5:0];
					next_st.prdata = {26'h0, st.bod};
				end
				`RBSC_ADDR_STAT:
					next_st.prdata = {29'h0, st.bod_int_sync[2], st.bod_irq, st.bod_rst};
				`RBSC_ADDR_PROT:
					next_st.prdata = {22'h0, st.acc, st.no_boot_pin, st.level};
				`RBSC_ADDR_CAPS:
					next_st.prdata = {26'h0, `RBSC_WATCHPOINTS, `RBSC_BREAKPOINTS};
				default: next_st.pslverr = 1'b1;
			endcase
		end
		if (rd)
			next_st.pslverr = next_st.pslverr;
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.irc_en <= 1'b1;
			st.flash_init <= 1'b1;
			st.bod <= `RBSC_CTRL_RST;
		end
		else
			st <= next_st;
	end

	assign pready_o = st.pready;
	assign prdata_o = st.prdata;
	assign pslverr_o = st.pslverr;
	assign chip_rst_n_o = st.chip_rst_n;
	assign irc_en_o = st.irc_en;
	assign flash_init_o = st.flash_init;
	assign fetch_valid_o = st.fetch_valid;
	assign bod_irq_o = st.bod_irq;
	assign swd_enable_o = st.acc.swd_enable;
	assign scan_enable_o = st.acc.scan_enable;
	assign isp_allowed_o = st.acc.isp_allowed;
	assign isp_sector0_o = st.acc.isp_sector0_allowed;
	assign isp_erase_only_o = st.acc.isp_erase_only;
	assign boot_pin_enable_o = st.acc.boot_pin_enable;
	assign iap_allowed_o = st.acc.iap_allowed;
	assign jtag_sel_o = st.jtag_sel;

	property p_src_resets;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.seq == rbsc_pkg::SEQ_RUN && watchdog_rst_i) |=> !chip_rst_n_o;
	endproperty
	a_src_resets: assert property (p_src_resets) else $error("source did not reset chip");
	property p_release;
		@(posedge mclk_i) disable iff (!rst_n)
		$rose(chip_rst_n_o) |-> !$past(any_src);
	endproperty
	a_release: assert property (p_release) else $error("released with source active");
	property p_irc;
		@(posedge mclk_i) disable iff (!rst_n)
		!chip_rst_n_o |-> irc_en_o && flash_init_o;
	endproperty
	a_irc: assert property (p_irc) else $error("oscillator off in reset");
	property p_fetch;
		@(posedge mclk_i) disable iff (!rst_n)
		fetch_valid_o |-> chip_rst_n_o && !flash_init_o;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch during reset");
	property p_bod_irq;
		@(posedge mclk_i) disable iff (!rst_n)
		(bod_int_lvl && st.bod.int_enable) |=> bod_irq_o;
	endproperty
	a_bod_irq: assert property (p_bod_irq) else $error("brownout irq missing");
	property p_bod_rst;
		@(posedge mclk_i) disable iff (!rst_n)
		(bod_rst_lvl && st.seq == rbsc_pkg::SEQ_RUN) |-> ##2 !chip_rst_n_o;
	endproperty
	a_bod_rst: assert property (p_bod_rst) else $error("brownout reset missing");
	property p_swd;
		@(posedge mclk_i) disable iff (!rst_n)
		swd_enable_o |-> chip_rst_n_o && level_none();
	endproperty
	function automatic logic level_none();
		return st.level == rbsc_pkg::PROT_NONE;
	endfunction : level_none
	a_swd: assert property (p_swd) else $error("debug open while reset or protected");
	property p_l3;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.level == rbsc_pkg::PROT_THREE) |-> !isp_allowed_o && !boot_pin_enable_o;
	endproperty
	a_l3: assert property (p_l3) else $error("level three leaks access");
	property p_scan;
		@(posedge mclk_i) disable iff (!rst_n)
		chip_rst_n_o |-> scan_enable_o && iap_allowed_o;
	endproperty
	a_scan: assert property (p_scan) else $error("scan or iap blocked");
	property p_src_pin;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.seq == rbsc_pkg::SEQ_RUN && !reset_pin_n_i) |=> !chip_rst_n_o;
	endproperty
	a_src_pin: assert property (p_src_pin) else $error("pin did not reset chip");
	property p_src_por;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.seq == rbsc_pkg::SEQ_RUN && por_i) |=> !chip_rst_n_o;
	endproperty
	a_src_por: assert property (p_src_por) else $error("power-on did not reset chip");
	property p_bod_src;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.seq == rbsc_pkg::SEQ_RUN && st.bod_rst) |=> !chip_rst_n_o;
	endproperty
	a_bod_src: assert property (p_bod_src) else $error("brownout did not reset chip");
	property p_hold;
		@(posedge mclk_i) disable iff (!rst_n)
		any_src |=> !chip_rst_n_o;
	endproperty
	a_hold: assert property (p_hold) else $error("chip ran with a source active");
	property p_fall_init;
		@(posedge mclk_i) disable iff (!rst_n)
		$fell(chip_rst_n_o) |-> flash_init_o && !fetch_valid_o;
	endproperty
	a_fall_init: assert property (p_fall_init) else $error("reset did not start flash init");
	property p_release_fetch;
		@(posedge mclk_i) disable iff (!rst_n)
		$rose(chip_rst_n_o) |-> fetch_valid_o && !flash_init_o;
	endproperty
	a_release_fetch: assert property (p_release_fetch) else $error("no fetch at release");
	property p_irq_off;
		@(posedge mclk_i) disable iff (!rst_n)
		!(bod_int_lvl && st.bod.int_enable) |=> !bod_irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("spurious brownout irq");
	property p_stat_read;
		@(posedge mclk_i) disable iff (!rst_n)
		(psel_i && penable_i && !pready_o && paddr_i == `RBSC_ADDR_STAT)
			|=> pready_o && prdata_o[2] == $past(st.bod_int_sync[2]);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status lost brownout level");
	property p_pat_l1;
		@(posedge mclk_i) disable iff (!rst_n)
		($rose(chip_rst_n_o) && $past(crp_word_i) == `RBSC_PAT_L1)
			|-> st.level == rbsc_pkg::PROT_ONE;
	endproperty
	a_pat_l1: assert property (p_pat_l1) else $error("level one pattern not taken");
	property p_pat_l3;
		@(posedge mclk_i) disable iff (!rst_n)
		($rose(chip_rst_n_o) && $past(crp_word_i) == `RBSC_PAT_L3)
			|-> st.level == rbsc_pkg::PROT_THREE;
	endproperty
	a_pat_l3: assert property (p_pat_l3) else $error("level three pattern not taken");
	property p_level_latch;
		@(posedge mclk_i) disable iff (!rst_n)
		$changed(st.level) |-> $rose(chip_rst_n_o);
	endproperty
	a_level_latch: assert property (p_level_latch) else $error("level moved outside release");
	property p_noboot_isp;
		@(posedge mclk_i) disable iff (!rst_n)
		st.no_boot_pin |-> isp_allowed_o && st.level == rbsc_pkg::PROT_NONE;
	endproperty
	a_noboot_isp: assert property (p_noboot_isp) else $error("boot pin lock raised protection");
	property p_noboot_pin;
		@(posedge mclk_i) disable iff (!rst_n)
		st.no_boot_pin |-> !boot_pin_enable_o;
	endproperty
	a_noboot_pin: assert property (p_noboot_pin) else $error("boot pin still sampled");
	property p_l1;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.level == rbsc_pkg::PROT_ONE) |-> !swd_enable_o && isp_allowed_o && !isp_sector0_o;
	endproperty
	a_l1: assert property (p_l1) else $error("level one access wrong");
	property p_l2;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.level == rbsc_pkg::PROT_TWO) |-> !swd_enable_o && isp_allowed_o && isp_erase_only_o;
	endproperty
	a_l2: assert property (p_l2) else $error("level two access wrong");
	property p_l3_debug;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.level == rbsc_pkg::PROT_THREE) |-> !swd_enable_o;
	endproperty
	a_l3_debug: assert property (p_l3_debug) else $error("level three leaks debug");
	property p_iap;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.level != rbsc_pkg::PROT_NONE) |-> iap_allowed_o;
	endproperty
	a_iap: assert property (p_iap) else $error("application programming blocked");
	property p_jtag_pin;
		@(posedge mclk_i) disable iff (!rst_n)
		(st.seq == rbsc_pkg::SEQ_RESET) |=> jtag_sel_o == !$past(reset_pin_n_i);
	endproperty
	a_jtag_pin: assert property (p_jtag_pin) else $error("debug mode not from pin");
	property p_swd_jtag;
		@(posedge mclk_i) disable iff (!rst_n)
		jtag_sel_o |-> !swd_enable_o;
	endproperty
	a_swd_jtag: assert property (p_swd_jtag) else $error("serial debug open in scan mode");
	property p_swd_reset;
		@(posedge mclk_i) disable iff (!rst_n)
		!chip_rst_n_o |-> !swd_enable_o;
	endproperty
	a_swd_reset: assert property (p_swd_reset) else $error("serial debug open in reset");
	property p_caps;
		@(posedge mclk_i) disable iff (!rst_n)
		(pready_o && $past(paddr_i) == `RBSC_ADDR_CAPS)
			|-> prdata_o[5:0] == {`RBSC_WATCHPOINTS, `RBSC_BREAKPOINTS};
	endproperty
	a_caps: assert property (p_caps) else $error("debug capability word wrong");
endmodule : reset_bod_security_control
`default_nettype wire

// ---- test/debug_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module debug_host
#(
	parameter int SCAN_WAIT = 25000
)
(
	// clock and controls
	input wire logic mclk_i,
	input wire logic por_i,
	input wire logic hold_low_i,
	// pin and status
	output logic reset_pin_n_o,
	output logic scan_ok_o
);
	int cnt = 0;
	// the host picks the debug mode by the pin level it drives
	assign reset_pin_n_o = !hold_low_i;
	always_ff @(posedge mclk_i)
	begin
		if (por_i)
			cnt <= 0;
		else if (cnt < SCAN_WAIT)
			cnt <= cnt + 1;
	end
	// scan is held back until the supply has long settled
	assign scan_ok_o = (cnt >= SCAN_WAIT);
endmodule : debug_host
`default_nettype wire

// ---- test/reset_bod_security_control_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rbsc_consts.svh"
module reset_bod_security_control_bench;
	logic mclk = 0, arst_n = 0, hold = 0, wdt = 0, por = 0;
	logic psel = 0, pen = 0, pwr = 0, pin_n, scan_ok;
	logic [3:0] below = 4'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, code_read_protection = 32'h0, rd;
	logic rdy, err, rst_n, internal_rc_oscillator, fl, fv, irq, swd, scan, in_system_programming, s0, eo, bp, in_application_programming, jt;
	logic [31:0] prd;
	int err_total = 0, checks_done = 0;
	debug_host host (.mclk_i(mclk), .por_i(por), .hold_low_i(hold),
		.reset_pin_n_o(pin_n), .scan_ok_o(scan_ok));
	reset_bod_security_control dut (.mclk_i(mclk), .arst_n_i(arst_n),
		.reset_pin_n_i(pin_n), .watchdog_rst_i(wdt), .por_i(por), .bod_below_i(below),
		.crp_word_i(code_read_protection), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(rdy), .prdata_o(prd),
		.pslverr_o(err), .chip_rst_n_o(rst_n), .irc_en_o(internal_rc_oscillator), .flash_init_o(fl),
		.fetch_valid_o(fv), .bod_irq_o(irq), .swd_enable_o(swd), .scan_enable_o(scan),
		.isp_allowed_o(in_system_programming), .isp_sector0_o(s0), .isp_erase_only_o(eo),
		.boot_pin_enable_o(bp), .iap_allowed_o(in_application_programming), .jtag_sel_o(jt));
	initial
	begin
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// the master never assumes a latency; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic exp_err);
		@(posedge mclk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1;
		do @(posedge mclk); while (rdy !== 1'b1);
		rd = prd;
		chk(err, exp_err);
		psel <= 0;
		pen <= 0;
	endtask : apb
	task automatic wait_run();
		int n;
		n = 0;
		while (rst_n !== 1'b1 && n < 200)
		begin
			@(negedge mclk);
			n++;
		end
		chk(rst_n, 1);
		chk(fv, 1);
	endtask : wait_run
	task automatic src_test(input int s);
		@(posedge mclk);
		if (s == 0) hold <= 1;
		if (s == 1) wdt <= 1;
		if (s == 2) por <= 1;
		repeat (6) @(negedge mclk);
		chk(rst_n, 0);
		chk({internal_rc_oscillator, fl}, 2'b11);
		chk(swd, 0);
		chk(jt, s == 0);
		@(posedge mclk);
		{hold, wdt, por} <= 3'b000;
		wait_run();
		apb(0, `RBSC_ADDR_CTRL, 0, 0);
		chk(rd, `RBSC_CTRL_RST);
		$display("source test %0d done", s);
	endtask : src_test
	task automatic bod_test();
		// control word: [5:4] irq level, [3:2] reset level, [1] reset on, [0] irq on
		apb(1, `RBSC_ADDR_CTRL, 32'h0000_0020, 0);
		below <= 4'h4;
		repeat (8) @(negedge mclk);
		chk(irq, 0);
		apb(0, `RBSC_ADDR_STAT, 0, 0);
		chk(rd[2:0], 3'b100);
		apb(1, `RBSC_ADDR_CTRL, 32'h0000_0021, 0);
		repeat (2) @(negedge mclk);
		chk(irq, 1);
		chk(rst_n, 1);
		apb(0, `RBSC_ADDR_STAT, 0, 0);
		chk(rd[2:1], 2'b11);
		apb(1, `RBSC_ADDR_CTRL, 32'h0000_0027, 0);
		below <= 4'h6;
		repeat (8) @(negedge mclk);
		chk(rst_n, 0);
		@(posedge mclk);
		below <= 4'h0;
		wait_run();
		apb(0, `RBSC_ADDR_CTRL, 0, 0);
		chk(rd, `RBSC_CTRL_RST);
		$display("brownout test done");
	endtask : bod_test
	task automatic prot_test();
		logic [31:0] pat [5];
		pat = '{32'h0, `RBSC_PAT_L1, `RBSC_PAT_L2, `RBSC_PAT_L3, `RBSC_PAT_NOBOOT};
		for (int i = 0; i < 5; i++)
		begin
			@(posedge mclk);
			code_read_protection <= pat[i];
			wdt <= 1;
			repeat (3) @(posedge mclk);
			wdt <= 0;
			wait_run();
			apb(0, `RBSC_ADDR_PROT, 0, 0);
			chk(rd[1:0], (i == 4) ? 0 : i);
			chk(swd, 5'b10001 >> i & 1);
			chk(in_system_programming, 5'b10111 >> i & 1);
			chk(bp, 5'b00111 >> i & 1);
			chk(eo, 5'b00100 >> i & 1);
			chk({scan, in_application_programming}, 2'b11);
			chk(s0, 5'b10001 >> i & 1);
		end
		$display("protection test done");
	endtask : prot_test
	// runs right after the power-on test, so the host count starts near zero
	task automatic scan_test();
		int n;
		n = 0;
		chk(scan_ok, 0);
		while (scan_ok !== 1'b1 && n < 30000)
		begin
			@(negedge mclk);
			n++;
		end
		chk(n > `RBSC_SCAN_WAIT_US * 96, 1);
		chk({scan_ok, scan}, 2'b11);
		$display("scan test done");
	endtask : scan_test
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (20) @(posedge mclk);
		arst_n <= 1;
		wait_run();
		apb(0, `RBSC_ADDR_CAPS, 0, 0);
		chk(rd[5:0], {`RBSC_WATCHPOINTS, `RBSC_BREAKPOINTS});
		apb(0, 12'h010, 0, 1);
		$display("reset and map test done");
		for (int s = 0; s < 3; s++)
			src_test(s);
		scan_test();
		bod_test();
		prot_test();
		finish_test();
	end
	initial
	begin
		#400000;
		err_total++;
		finish_test();
	end
endmodule : reset_bod_security_control_bench
`default_nettype wire
